// ==== rtl/gic_defines.svh ====
// constants for the guest instruction intercept check
`ifndef GIC_DEFINES_SVH
`define GIC_DEFINES_SVH
`define GIC_TASK_SWITCHED_BIT 3
`define GIC_MONITOR_COPROC_BIT 1
`define GIC_PAUSE_CNT_W 16
`define GIC_PAUSE_CNT_RST 16'h0000
`define GIC_FEAT_PAUSE_FILTER_BIT 10
`define GIC_EXT_FEAT_LEAF 32'h8000000A
`define GIC_SWINT_EXC_LAST 8'h1F
`endif

// ==== rtl/gic_pkg.sv ====
// types for the guest instruction intercept check
package gic_pkg;
  typedef enum logic [4:0] {
    GIC_OP_NONE,
    GIC_OP_MOV_TO_CR0,
    GIC_OP_MOV_FROM_CR0,
    GIC_OP_LOAD_STATUS_WORD,
    GIC_OP_STORE_STATUS_WORD,
    GIC_OP_CLEAR_TASK_SWITCHED,
    GIC_OP_TABLE_REG_ACCESS,
    GIC_OP_READ_TIMESTAMP,
    GIC_OP_READ_PERF_COUNTER,
    GIC_OP_PUSH_FLAGS,
    GIC_OP_POP_FLAGS,
    GIC_OP_PROCESSOR_ID_QUERY,
    GIC_OP_SYSTEM_MGMT_RETURN,
    GIC_OP_INTERRUPT_RETURN,
    GIC_OP_SOFTWARE_INTERRUPT,
    GIC_OP_CACHE_INVALIDATE,
    GIC_OP_PAUSE,
    GIC_OP_HALT,
    GIC_OP_PAGE_INVALIDATE
  } gic_op_t;

  typedef enum logic [4:0] {
    GIC_EXIT_NONE,
    GIC_EXIT_CR0_READ,
    GIC_EXIT_CR0_WRITE,
    GIC_EXIT_CR0_SEL_WRITE,
    GIC_EXIT_TABLE_REG,
    GIC_EXIT_READ_TIMESTAMP,
    GIC_EXIT_READ_PERF_COUNTER,
    GIC_EXIT_PUSH_FLAGS,
    GIC_EXIT_POP_FLAGS,
    GIC_EXIT_PROCESSOR_ID,
    GIC_EXIT_SYSTEM_MGMT_RETURN,
    GIC_EXIT_INTERRUPT_RETURN,
    GIC_EXIT_SOFTWARE_INTERRUPT,
    GIC_EXIT_CACHE_INVALIDATE,
    GIC_EXIT_PAUSE,
    GIC_EXIT_HALT,
    GIC_EXIT_PAGE_INVALIDATE
  } gic_exit_t;

  typedef enum logic [1:0] {
    GIC_RES_RETIRE,
    GIC_RES_FAULT,
    GIC_RES_EXIT
  } gic_res_t;
endpackage : gic_pkg

// ==== rtl/gic_pause_filter.sv ====
// pause filter counter
`timescale 1ns/1ns
`default_nettype none
`include "gic_defines.svh"
module gic_pause_filter #(
  parameter int CNT_W = `GIC_PAUSE_CNT_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // control
  input wire logic filterSupported,
  input wire logic guestEntry,
  input wire logic reloadEvent,
  input wire logic [CNT_W-1:0] pauseFilterCount,
  input wire logic pauseExec,
  input wire logic pauseInterceptEn,
  // result
  output logic pauseFire,
  output logic [CNT_W-1:0] pauseCount
);
  if (CNT_W < 1 || CNT_W > 32) begin : gBadWidth
    $error("bad CNT_W");
  end

  logic expired;
  logic [CNT_W-1:0] next_pauseCount;

  // counter never goes below zero: it holds at zero, and is expired at zero or when the filter is unsupported
  assign expired = !filterSupported || (pauseCount == '0);
  assign pauseFire = pauseExec && pauseInterceptEn && expired;
  assign next_pauseCount = expired ? pauseCount : pauseCount - CNT_W'(1);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pauseCount <= '0;
    end else if (guestEntry) begin
      pauseCount <= pauseFilterCount;
    end else if (reloadEvent) begin
      pauseCount <= pauseFilterCount;
    end else if (pauseExec && !pauseFire) begin
      pauseCount <= next_pauseCount;
    end
  end
endmodule : gic_pause_filter
`default_nettype wire

// ==== rtl/gic_intercept_check.sv ====
// guest instruction intercept decision and exception ordering
// How it works
// - selective write fires only beyond TS/MP
// - non-selective write intercept wins over selective
// - cr0 write checks non-memory faults first
// - selective ordered like generic cr0 write
// - status word intercept before memory faults
// - load status word: selective acts non-selective
// - table regs: after opcode/gp faults, before memory
// - counter reads check all faults first
// - flags push/pop intercept beats faults
// - id query intercept has no fault check
// - mgmt return and interrupt return intercept first
// - software interrupt intercept first, own pc
// - vectors 0-31 skip exception intercepts
// - cache invalidate checks gp first
// - guest entry loads pause counter
// - pause decrements; fires at zero if enabled
// - block field never written back
// - mgmt interrupt may reload counter
// - pause filter support at edx bit 10
// - count zero: first pause interceptable
// - halt checks all faults first
// - page invalidate checks all faults first
`timescale 1ns/1ns
`default_nettype none
`include "gic_defines.svh"
module gic_intercept_check #(
  parameter int CNT_W = `GIC_PAUSE_CNT_W,
  parameter bit PAUSE_FILTER_SUPPORTED = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // instruction from decode
  input wire logic instrValid,
  input wire gic_pkg::gic_op_t instrOp,
  input wire logic [63:0] instrPc,
  input wire logic [15:0] instrCs,
  input wire logic [31:0] cr0Old,
  input wire logic [31:0] cr0New,
  input wire logic [7:0] swIntVector,
  input wire logic [31:0] idLeaf,
  // exception status from decode
  input wire logic nonMemFault,
  input wire logic memFault,
  input wire logic opcodeOrGpFault,
  // intercept enables from the guest control block
  input wire logic icptCr0Read,
  input wire logic icptCr0Write,
  input wire logic icptCr0SelWrite,
  input wire logic icptTableReg,
  input wire logic icptReadTimestamp,
  input wire logic icptReadPerfCounter,
  input wire logic icptPushFlags,
  input wire logic icptPopFlags,
  input wire logic icptProcessorId,
  input wire logic icptSystemMgmtReturn,
  input wire logic icptInterruptReturn,
  input wire logic icptSoftwareInterrupt,
  input wire logic icptCacheInvalidate,
  input wire logic icptPause,
  input wire logic icptHalt,
  input wire logic icptPageInvalidate,
  // pause filter
  input wire logic guestEntry,
  input wire logic systemMgmtInterrupt,
  input wire logic [CNT_W-1:0] pauseFilterCount,
  // results
  output logic resValid,
  output gic_pkg::gic_res_t result,
  output gic_pkg::gic_exit_t exitCode,
  output logic [63:0] exitPc,
  output logic [15:0] exitCs,
  output logic [7:0] exitInfo,
  output logic suppressExcIntercept,
  output logic [31:0] idEdxFeature,
  output logic [CNT_W-1:0] pauseCount
);
  if (CNT_W < 1 || CNT_W > 32) begin : gBadWidth
    $error("bad CNT_W");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic cr0OtherChange(input logic [31:0] oldV, input logic [31:0] newV);
    logic [31:0] mask;
    mask = 32'hFFFFFFFF;
    mask[`GIC_TASK_SWITCHED_BIT] = 1'b0;
    mask[`GIC_MONITOR_COPROC_BIT] = 1'b0;
    cr0OtherChange = |((oldV ^ newV) & mask);
  endfunction : cr0OtherChange

  // ----------------------------------------
  // pause filter
  // ----------------------------------------
  logic pauseExec;
  logic pauseFire;
  assign pauseExec = instrValid && (instrOp == gic_pkg::GIC_OP_PAUSE);

  gic_pause_filter #(
    .CNT_W(CNT_W)
  ) uPause (
    .mclk(mclk),
    .rstn(rstn),
    .filterSupported(PAUSE_FILTER_SUPPORTED),
    .guestEntry(guestEntry),
    .reloadEvent(systemMgmtInterrupt),
    .pauseFilterCount(pauseFilterCount),
    .pauseExec(pauseExec),
    .pauseInterceptEn(icptPause),
    .pauseFire(pauseFire),
    .pauseCount(pauseCount)
  );

  // ----------------------------------------
  // decision
  // ----------------------------------------
  gic_pkg::gic_res_t next_result;
  gic_pkg::gic_exit_t next_exitCode;
  logic next_suppressExc;

  always_comb begin
    next_result = gic_pkg::GIC_RES_RETIRE;
    next_exitCode = gic_pkg::GIC_EXIT_NONE;
    next_suppressExc = 1'b0;
    unique case (instrOp)
      gic_pkg::GIC_OP_MOV_TO_CR0: begin
        if (nonMemFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptCr0Write) begin
          next_exitCode = gic_pkg::GIC_EXIT_CR0_WRITE;
        end else if (icptCr0SelWrite && cr0OtherChange(cr0Old, cr0New)) begin
          next_exitCode = gic_pkg::GIC_EXIT_CR0_SEL_WRITE;
        end else if (memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_LOAD_STATUS_WORD: begin
        if (nonMemFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptCr0Write) begin
          next_exitCode = gic_pkg::GIC_EXIT_CR0_WRITE;
        end else if (icptCr0SelWrite) begin
          next_exitCode = gic_pkg::GIC_EXIT_CR0_SEL_WRITE;
        end else if (memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_MOV_FROM_CR0, gic_pkg::GIC_OP_STORE_STATUS_WORD: begin
        if (nonMemFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptCr0Read) begin
          next_exitCode = gic_pkg::GIC_EXIT_CR0_READ;
        end else if (memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_CLEAR_TASK_SWITCHED: begin
        if (nonMemFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptCr0Write) begin
          next_exitCode = gic_pkg::GIC_EXIT_CR0_WRITE;
        end
      end
      gic_pkg::GIC_OP_TABLE_REG_ACCESS: begin
        if (opcodeOrGpFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptTableReg) begin
          next_exitCode = gic_pkg::GIC_EXIT_TABLE_REG;
        end else if (memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_READ_TIMESTAMP: begin
        if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptReadTimestamp) begin
          next_exitCode = gic_pkg::GIC_EXIT_READ_TIMESTAMP;
        end
      end
      gic_pkg::GIC_OP_READ_PERF_COUNTER: begin
        if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptReadPerfCounter) begin
          next_exitCode = gic_pkg::GIC_EXIT_READ_PERF_COUNTER;
        end
      end
      gic_pkg::GIC_OP_PUSH_FLAGS: begin
        if (icptPushFlags) begin
          next_exitCode = gic_pkg::GIC_EXIT_PUSH_FLAGS;
        end else if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_POP_FLAGS: begin
        if (icptPopFlags) begin
          next_exitCode = gic_pkg::GIC_EXIT_POP_FLAGS;
        end else if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_PROCESSOR_ID_QUERY: begin
        if (icptProcessorId) begin
          next_exitCode = gic_pkg::GIC_EXIT_PROCESSOR_ID;
        end
      end
      gic_pkg::GIC_OP_SYSTEM_MGMT_RETURN: begin
        if (icptSystemMgmtReturn) begin
          next_exitCode = gic_pkg::GIC_EXIT_SYSTEM_MGMT_RETURN;
        end else if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_INTERRUPT_RETURN: begin
        if (icptInterruptReturn) begin
          next_exitCode = gic_pkg::GIC_EXIT_INTERRUPT_RETURN;
        end else if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_SOFTWARE_INTERRUPT: begin
        next_suppressExc = (swIntVector <= `GIC_SWINT_EXC_LAST);
        if (icptSoftwareInterrupt) begin
          next_exitCode = gic_pkg::GIC_EXIT_SOFTWARE_INTERRUPT;
        end else if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
      gic_pkg::GIC_OP_CACHE_INVALIDATE: begin
        if (nonMemFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptCacheInvalidate) begin
          next_exitCode = gic_pkg::GIC_EXIT_CACHE_INVALIDATE;
        end
      end
      gic_pkg::GIC_OP_PAUSE: begin
        if (pauseFire) begin
          next_exitCode = gic_pkg::GIC_EXIT_PAUSE;
        end
      end
      gic_pkg::GIC_OP_HALT: begin
        if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptHalt) begin
          next_exitCode = gic_pkg::GIC_EXIT_HALT;
        end
      end
      gic_pkg::GIC_OP_PAGE_INVALIDATE: begin
        if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end else if (icptPageInvalidate) begin
          next_exitCode = gic_pkg::GIC_EXIT_PAGE_INVALIDATE;
        end
      end
      default: begin
        if (nonMemFault || memFault) begin
          next_result = gic_pkg::GIC_RES_FAULT;
        end
      end
    endcase
    if (next_exitCode != gic_pkg::GIC_EXIT_NONE) begin
      next_result = gic_pkg::GIC_RES_EXIT;
    end
  end

  // ----------------------------------------
  // registered outcome
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      resValid <= 1'b0;
      result <= gic_pkg::GIC_RES_RETIRE;
      exitCode <= gic_pkg::GIC_EXIT_NONE;
      suppressExcIntercept <= 1'b0;
    end else begin
      resValid <= instrValid && (instrOp != gic_pkg::GIC_OP_NONE);
      result <= next_result;
      exitCode <= next_exitCode;
      suppressExcIntercept <= instrValid && next_suppressExc;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      exitPc <= 64'h0;
      exitCs <= 16'h0;
      exitInfo <= 8'h00;
    end else if (instrValid) begin
      exitPc <= instrPc;
      exitCs <= instrCs;
      exitInfo <= (instrOp == gic_pkg::GIC_OP_SOFTWARE_INTERRUPT) ? swIntVector : 8'h00;
    end
  end

  // ----------------------------------------
  // feature report
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      idEdxFeature <= 32'h0;
    end else if (instrValid && instrOp == gic_pkg::GIC_OP_PROCESSOR_ID_QUERY) begin
      idEdxFeature <= 32'h0;
      if (idLeaf == `GIC_EXT_FEAT_LEAF) begin
        idEdxFeature[`GIC_FEAT_PAUSE_FILTER_BIT] <= PAUSE_FILTER_SUPPORTED;
      end
    end
  end
endmodule : gic_intercept_check
`default_nettype wire

// ==== verif/gic_check_assertions.sv ====
// port assertions for the guest instruction intercept check
`timescale 1ns/1ns
`default_nettype none
`include "gic_defines.svh"
module gic_check_assertions #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // instruction and faults
  input wire logic instrValid,
  input wire gic_pkg::gic_op_t instrOp,
  input wire logic [31:0] cr0Old,
  input wire logic [31:0] cr0New,
  input wire logic nonMemFault,
  input wire logic memFault,
  // enables and pause
  input wire logic icptCr0Write,
  input wire logic icptPushFlags,
  input wire logic icptHalt,
  input wire logic guestEntry,
  input wire logic [CNT_W-1:0] pauseFilterCount,
  // results
  input wire logic resValid,
  input wire gic_pkg::gic_res_t result,
  input wire gic_pkg::gic_exit_t exitCode,
  input wire logic [CNT_W-1:0] pauseCount
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  localparam logic [31:0] TS_MP = (32'h1 << `GIC_TASK_SWITCHED_BIT)
    | (32'h1 << `GIC_MONITOR_COPROC_BIT);
  logic taken;
  assign taken = instrValid && (instrOp != gic_pkg::GIC_OP_NONE);
  sequence haltTaken;
    instrValid && instrOp == gic_pkg::GIC_OP_HALT;
  endsequence
  sequence haltClean;
    icptHalt && !nonMemFault && !memFault;
  endsequence
  sequence haltFault;
    nonMemFault;
  endsequence
  sequence haltExit;
    result == gic_pkg::GIC_RES_EXIT && exitCode == gic_pkg::GIC_EXIT_HALT;
  endsequence
  sequence faulted;
    result == gic_pkg::GIC_RES_FAULT;
  endsequence
  sequence pushTaken;
    instrValid && instrOp == gic_pkg::GIC_OP_PUSH_FLAGS && icptPushFlags;
  endsequence
  sequence pushExit;
    exitCode == gic_pkg::GIC_EXIT_PUSH_FLAGS;
  endsequence
  sequence writeWin;
    instrValid && icptCr0Write && !nonMemFault
      && (instrOp == gic_pkg::GIC_OP_MOV_TO_CR0
      || instrOp == gic_pkg::GIC_OP_LOAD_STATUS_WORD);
  endsequence
  sequence tsMpWrite;
    instrValid && instrOp == gic_pkg::GIC_OP_MOV_TO_CR0 && !icptCr0Write
      && !nonMemFault && !memFault && ((cr0Old ^ cr0New) & ~TS_MP) == 32'h0;
  endsequence
  resp_latency_a: assert property (taken |=> resValid)
    else $error("no outcome one cycle after an instruction");
  resp_none_a: assert property (!taken |=> !resValid)
    else $error("outcome without an instruction");
  halt_exit_a: assert property (haltTaken and haltClean |=> haltExit)
    else $error("halt intercept did not exit");
  halt_fault_a: assert property (haltTaken and haltFault |=> faulted)
    else $error("halt fault not ahead of intercept");
  flags_first_a: assert property (pushTaken |=> pushExit)
    else $error("push flags intercept lost to a fault");
  nonsel_wins_a: assert property (writeWin |=> exitCode == gic_pkg::GIC_EXIT_CR0_WRITE)
    else $error("non-selective write not reported");
  ts_mp_only_a: assert property (tsMpWrite |=> result == gic_pkg::GIC_RES_RETIRE)
    else $error("selective write fired on ts or mp change");
  entry_load_a: assert property (guestEntry |=> pauseCount == $past(pauseFilterCount))
    else $error("guest entry did not load pause counter");
endmodule : gic_check_assertions
`default_nettype wire

// ==== verif/gic_pipe_model.sv ====
// execute stage model collecting each outcome
`timescale 1ns/1ns
`default_nettype none
module gic_pipe_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // outcome from the check
  input wire logic resValid,
  input wire gic_pkg::gic_res_t result,
  input wire gic_pkg::gic_exit_t exitCode,
  input wire logic suppressExcIntercept,
  // collected outcome
  output logic got,
  output gic_pkg::gic_res_t gotRes,
  output gic_pkg::gic_exit_t gotCode,
  output logic gotSup
);
  always_ff @(posedge mclk) begin
    got <= rstn && resValid;
    if (resValid) begin
      gotRes <= result;
      gotCode <= exitCode;
      gotSup <= suppressExcIntercept;
    end
  end
endmodule : gic_pipe_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// testbench for the guest instruction intercept check
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int CNT_W = 16;
  localparam logic [31:0] XF = 32'h000681C0;
  localparam gic_pkg::gic_res_t RT = gic_pkg::GIC_RES_RETIRE;
  localparam gic_pkg::gic_res_t FT = gic_pkg::GIC_RES_FAULT;
  localparam gic_pkg::gic_res_t EX = gic_pkg::GIC_RES_EXIT;
  logic mclk = 1'b0, rstn = 1'b0, instrValid = 1'b0, guestEntry = 1'b0, sysMgmtInt = 1'b0;
  gic_pkg::gic_op_t instrOp = gic_pkg::GIC_OP_NONE;
  logic [63:0] instrPc = 64'h0;
  logic [15:0] instrCs = 16'h0, ic = 16'h0;
  logic [31:0] cr0Old = 32'h0, cr0New = 32'h0, idLeaf = 32'h0;
  logic [7:0] swIntVector = 8'h0;
  logic [1:0] flt = 2'h0;
  logic [CNT_W-1:0] pauseFilterCount = 16'h0;
  logic resValid, suppressExcIntercept, got, gotSup;
  gic_pkg::gic_res_t result, gotRes;
  gic_pkg::gic_exit_t exitCode, gotCode;
  logic [63:0] exitPc;
  logic [15:0] exitCs;
  logic [7:0] exitInfo;
  logic [31:0] idEdxFeature;
  logic [CNT_W-1:0] pauseCount;
  int fail_count = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  gic_intercept_check #(.CNT_W(CNT_W)) gic_intercept_check_i (
    .mclk, .rstn, .instrValid, .instrOp, .instrPc, .instrCs, .cr0Old, .cr0New,
    .swIntVector, .idLeaf, .nonMemFault(flt[1]), .memFault(flt[0]), .opcodeOrGpFault(flt[1]),
    .icptCr0Read(ic[0]), .icptCr0Write(ic[1]), .icptCr0SelWrite(ic[2]), .icptTableReg(ic[3]),
    .icptReadTimestamp(ic[4]), .icptReadPerfCounter(ic[5]), .icptPushFlags(ic[6]),
    .icptPopFlags(ic[7]), .icptProcessorId(ic[8]), .icptSystemMgmtReturn(ic[9]),
    .icptInterruptReturn(ic[10]), .icptSoftwareInterrupt(ic[11]),
    .icptCacheInvalidate(ic[12]), .icptPause(ic[13]), .icptHalt(ic[14]),
    .icptPageInvalidate(ic[15]), .guestEntry, .systemMgmtInterrupt(sysMgmtInt),
    .pauseFilterCount, .resValid, .result, .exitCode, .exitPc, .exitCs, .exitInfo,
    .suppressExcIntercept, .idEdxFeature, .pauseCount
  );
  gic_pipe_model gic_pipe_model_i (
    .mclk, .rstn, .resValid, .result, .exitCode, .suppressExcIntercept, .got, .gotRes,
    .gotCode, .gotSup
  );
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task automatic run_case(input gic_pkg::gic_op_t op, input logic [31:0] nw,
      input logic [15:0] icv, input logic [1:0] f, input gic_pkg::gic_res_t er,
      input gic_pkg::gic_exit_t ee);
    int n;
    n = 0;
    instrOp = op;
    cr0New = nw;
    ic = icv;
    flt = f;
    instrPc = instrPc + 64'h10;
    instrCs = instrCs + 16'h8;
    instrValid = 1'b1;
    @(negedge mclk);
    instrValid = 1'b0;
    while (got !== 1'b1 && n < 6) begin
      @(negedge mclk);
      n++;
    end
    if (got !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end else begin
      chk("result", er, gotRes);
      if (er == EX) begin
        chk("exitCode", ee, gotCode);
      end
    end
  endtask : run_case
  task automatic pulse_ev(input logic reload);
    guestEntry = !reload;
    sysMgmtInt = reload;
    @(negedge mclk);
    guestEntry = 1'b0;
    sysMgmtInt = 1'b0;
    @(negedge mclk);
  endtask : pulse_ev
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_cr0();
    gic_pkg::gic_op_t mv, ld, sw;
    gic_pkg::gic_exit_t sel;
    mv = gic_pkg::GIC_OP_MOV_TO_CR0;
    ld = gic_pkg::GIC_OP_LOAD_STATUS_WORD;
    sw = gic_pkg::GIC_OP_STORE_STATUS_WORD;
    sel = gic_pkg::GIC_EXIT_CR0_SEL_WRITE;
    run_case(mv, 32'hA, 16'h4, 2'h0, RT, sel);
    run_case(mv, 32'h1, 16'h4, 2'h0, EX, sel);
    run_case(mv, 32'h1, 16'h6, 2'h0, EX, gic_pkg::GIC_EXIT_CR0_WRITE);
    run_case(mv, 32'h1, 16'h4, 2'h2, FT, sel);
    run_case(mv, 32'h1, 16'h4, 2'h1, EX, sel);
    run_case(ld, 32'h8, 16'h4, 2'h1, EX, sel);
    run_case(gic_pkg::GIC_OP_CLEAR_TASK_SWITCHED, 32'h1, 16'h4, 2'h0, RT, sel);
    run_case(sw, 32'h0, 16'h1, 2'h1, EX, gic_pkg::GIC_EXIT_CR0_READ);
  endtask : s_cr0
  task automatic s_order();
    gic_pkg::gic_op_t op;
    gic_pkg::gic_exit_t ee;
    gic_pkg::gic_res_t er;
    for (int k = 6; k <= 18; k++) begin
      op = gic_pkg::gic_op_t'(k);
      ee = gic_pkg::gic_exit_t'(k - 2);
      for (int f = 0; f < 2; f++) begin
        er = (f == 1 && XF[k]) ? FT : EX;
        if (k == 16) begin
          continue;
        end
        if (XF[k]) begin
          run_case(op, 32'h0, 16'hFFF8, {2{f[0]}}, er, ee);
        end else begin
          run_case(op, 32'h0, 16'hFFF8, {2{f[0]}}, er, ee);
        end
      end
    end
    op = gic_pkg::GIC_OP_TABLE_REG_ACCESS;
    run_case(op, 32'h0, 16'h8, 2'h1, EX, gic_pkg::GIC_EXIT_TABLE_REG);
  endtask : s_order
  task automatic s_swint();
    gic_pkg::gic_op_t si;
    si = gic_pkg::GIC_OP_SOFTWARE_INTERRUPT;
    swIntVector = 8'h03;
    run_case(si, 32'h0, 16'h0, 2'h0, RT, gic_pkg::GIC_EXIT_NONE);
    chk("suppressExcIntercept", 64'h1, gotSup);
    swIntVector = 8'h20;
    run_case(si, 32'h0, 16'h0, 2'h0, RT, gic_pkg::GIC_EXIT_NONE);
    chk("suppressExcIntercept", 64'h0, gotSup);
    swIntVector = 8'h1F;
    run_case(si, 32'h0, 16'h0800, 2'h3, EX, gic_pkg::GIC_EXIT_SOFTWARE_INTERRUPT);
    chk("exitPc", instrPc, exitPc);
    chk("exitCs", instrCs, exitCs);
    chk("exitInfo", 64'h1F, exitInfo);
    chk("suppressExcIntercept", 64'h1, gotSup);
  endtask : s_swint
  task automatic s_pause();
    gic_pkg::gic_op_t pz;
    pz = gic_pkg::GIC_OP_PAUSE;
    pauseFilterCount = 16'h0002;
    pulse_ev(1'b0);
    chk("pauseCount", 64'h2, pauseCount);
    run_case(pz, 32'h0, 16'h2000, 2'h0, RT, gic_pkg::GIC_EXIT_NONE);
    chk("pauseCount", 64'h1, pauseCount);
    run_case(pz, 32'h0, 16'h0, 2'h0, RT, gic_pkg::GIC_EXIT_NONE);
    run_case(pz, 32'h0, 16'h2000, 2'h0, EX, gic_pkg::GIC_EXIT_PAUSE);
    chk("pauseCount", 64'h0, pauseCount);
    pulse_ev(1'b1);
    chk("pauseCount", 64'h2, pauseCount);
    pauseFilterCount = 16'h0000;
    pulse_ev(1'b0);
    run_case(pz, 32'h0, 16'h2000, 2'h0, EX, gic_pkg::GIC_EXIT_PAUSE);
  endtask : s_pause
  task automatic s_id();
    gic_pkg::gic_op_t q;
    q = gic_pkg::GIC_OP_PROCESSOR_ID_QUERY;
    idLeaf = 32'h8000000A;
    run_case(q, 32'h0, 16'h0, 2'h0, RT, gic_pkg::GIC_EXIT_NONE);
    chk("idEdxFeature10", 64'h1, idEdxFeature[10]);
    idLeaf = 32'h00000001;
    run_case(q, 32'h0, 16'h0, 2'h0, RT, gic_pkg::GIC_EXIT_NONE);
    chk("idEdxFeature10", 64'h0, idEdxFeature[10]);
  endtask : s_id
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    s_cr0();
    s_order();
    s_swint();
    s_pause();
    s_id();
    report_and_stop();
  end
endmodule : tb_top
bind gic_intercept_check gic_check_assertions #(.CNT_W(CNT_W)) gic_check_assertions_i (
  .mclk, .rstn, .instrValid, .instrOp, .cr0Old, .cr0New, .nonMemFault, .memFault,
  .icptCr0Write, .icptPushFlags, .icptHalt, .guestEntry, .pauseFilterCount,
  .resValid, .result, .exitCode, .pauseCount
);
`default_nettype wire
